/* File: rtl/dic_irq_slice.sv */
// ahb slave with error mask, clear registers and combined summary
`timescale 1ns/1ps
module dic_irq_slice
  import dic_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic hready_in,
  input wire logic [31:0] hwdata_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire logic [1:0] transfer_done_set_in,
  input wire logic [1:0] block_done_set_in,
  input wire logic [1:0] source_txn_set_in,
  input wire logic [1:0] dest_txn_set_in,
  input wire logic [1:0] error_set_in,
  input wire logic [1:0] transfer_done_mask_in,
  input wire logic [1:0] block_done_mask_in,
  input wire logic [1:0] source_txn_mask_in,
  input wire logic [1:0] dest_txn_mask_in,
  output logic [1:0] error_irq_mask_out,
  output logic transfer_done_irq_out,
  output logic block_done_irq_out,
  output logic source_txn_irq_out,
  output logic dest_txn_irq_out,
  output logic error_irq_out
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic wr_pend;
    dic_reg_t wsel;
    logic [1:0] err_mask;
    logic [31:0] rdata;
    logic [4:0] irq;
    logic ready;
  } dic_state_t;

  dic_state_t st;
  dic_state_t next_st;

  logic [DIC_NTYPE-1:0][1:0] set_v;
  logic [DIC_NTYPE-1:0][1:0] clr_v;
  logic [DIC_NTYPE-1:0][1:0] mask_v;
  logic [DIC_NTYPE-1:0][1:0] pend_v;
  logic [DIC_NTYPE-1:0][1:0] stat_v;
  logic [4:0] summary;
  logic addr_valid;
  dic_reg_t asel;

  function automatic dic_reg_t dic_decode(input logic [31:0] a);
    dic_reg_t r;
    r = DIC_REG_NONE;
    unique case (a)
      DIC_ADDR_ERR_MASK: r = DIC_REG_MASK;
      DIC_ADDR_CLR_TFR: r = DIC_REG_CLR_TFR;
      DIC_ADDR_CLR_BLK: r = DIC_REG_CLR_BLK;
      DIC_ADDR_CLR_SRC: r = DIC_REG_CLR_SRC;
      DIC_ADDR_CLR_DST: r = DIC_REG_CLR_DST;
      DIC_ADDR_CLR_ERR: r = DIC_REG_CLR_ERR;
      DIC_ADDR_SUMMARY: r = DIC_REG_SUMMARY;
      default: r = DIC_REG_NONE;
    endcase
    return r;
  endfunction

  // ************************************************************
  // pending bits per type
  // ************************************************************
  assign set_v = {error_set_in, dest_txn_set_in, source_txn_set_in,
                  block_done_set_in, transfer_done_set_in};
  assign mask_v = {st.err_mask, dest_txn_mask_in, source_txn_mask_in,
                   block_done_mask_in, transfer_done_mask_in};

  always_comb begin
    clr_v = '0;
    if (st.wr_pend) begin
      unique case (st.wsel)
        DIC_REG_CLR_TFR: clr_v[DIC_T_TFR] = hwdata_in[DIC_CLR_LSB +: 2];
        DIC_REG_CLR_BLK: clr_v[DIC_T_BLK] = hwdata_in[DIC_CLR_LSB +: 2];
        DIC_REG_CLR_SRC: clr_v[DIC_T_SRC] = hwdata_in[DIC_CLR_LSB +: 2];
        DIC_REG_CLR_DST: clr_v[DIC_T_DST] = hwdata_in[DIC_CLR_LSB +: 2];
        DIC_REG_CLR_ERR: clr_v[DIC_T_ERR] = hwdata_in[DIC_CLR_LSB +: 2];
        default: clr_v = '0;
      endcase
    end
  end

  for (genvar t = 0; t < DIC_NTYPE; t++) begin : g_type
    dic_pend u_pend (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .set_in(set_v[t]),
      .clr_in(clr_v[t]),
      .mask_in(mask_v[t]),
      .pend_out(pend_v[t]),
      .status_out(stat_v[t])
    );
    // one bit per type, OR of its status
    assign summary[t] = |stat_v[t];
  end

  // ************************************************************
  // bus side
  // ************************************************************
  assign addr_valid = hsel_in && hready_in &&
    (htrans_in == DIC_HTRANS_NONSEQ || htrans_in == DIC_HTRANS_SEQ);
  assign asel = dic_decode(haddr_in);

  always_comb begin
    next_st = st;
    next_st.ready = 1'b1;
    next_st.irq = summary;
    next_st.wr_pend = addr_valid && hwrite_in;
    next_st.wsel = asel;
    // mask bit moves only with its strobe
    if (st.wr_pend && st.wsel == DIC_REG_MASK) begin
      for (int c = 0; c < DIC_NCH; c++) begin
        if (hwdata_in[DIC_STRB_LSB + c]) begin
          next_st.err_mask[c] = hwdata_in[DIC_MASK_LSB + c];
        end
      end
    end
    // reserved and write-only fields read zero
    next_st.rdata = '0;
    if (addr_valid && !hwrite_in) begin
      unique case (asel)
        DIC_REG_MASK: next_st.rdata[DIC_MASK_LSB +: 2] = st.err_mask;
        DIC_REG_SUMMARY: next_st.rdata[4:0] = summary;
        default: next_st.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st.wr_pend <= 1'b0;
      st.wsel <= DIC_REG_NONE;
      st.err_mask <= DIC_MASK_RST;
      st.rdata <= DIC_RDATA_RST;
      st.irq <= DIC_IRQ_RST;
      st.ready <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign hrdata_out = st.rdata;
  assign hreadyout_out = st.ready;
  assign hresp_out = 1'b0;
  assign error_irq_mask_out = st.err_mask;
  assign transfer_done_irq_out = st.irq[DIC_T_TFR];
  assign block_done_irq_out = st.irq[DIC_T_BLK];
  assign source_txn_irq_out = st.irq[DIC_T_SRC];
  assign dest_txn_irq_out = st.irq[DIC_T_DST];
  assign error_irq_out = st.irq[DIC_T_ERR];

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_mask_wr;
    st.wr_pend && st.wsel == DIC_REG_MASK;
  endsequence
  sequence s_clr_err_wr;
    st.wr_pend && st.wsel == DIC_REG_CLR_ERR;
  endsequence
  sequence s_sum_rd;
    addr_valid && !hwrite_in && asel == DIC_REG_SUMMARY;
  endsequence
  sequence s_mask_rd;
    addr_valid && !hwrite_in && asel == DIC_REG_MASK;
  endsequence
  sequence s_wo_rd;
    addr_valid && !hwrite_in && asel != DIC_REG_MASK && asel != DIC_REG_SUMMARY;
  endsequence

  a_err_gate: assert property (stat_v[DIC_T_ERR] == (pend_v[DIC_T_ERR] & st.err_mask))
    else $error("error status not gated by mask");
  a_mask_strobe: assert property (s_mask_wr |=> st.err_mask[0] ==
      ($past(hwdata_in[8]) ? $past(hwdata_in[0]) : $past(st.err_mask[0])))
    else $error("mask bit 0 strobe misbehaved");
  a_mask_hold: assert property (!st.wr_pend |=> $stable(st.err_mask))
    else $error("mask changed without a write");
  a_clear_one: assert property (s_clr_err_wr ##0 (hwdata_in[1] && !error_set_in[1])
      |=> !pend_v[DIC_T_ERR][1])
    else $error("error pending bit not cleared");
  a_clear_zero: assert property ((st.wr_pend && st.wsel == DIC_REG_CLR_TFR
      && !hwdata_in[0] && pend_v[DIC_T_TFR][0]) |=> pend_v[DIC_T_TFR][0])
    else $error("zero clear bit disturbed pending");
  a_set_wins: assert property ((error_set_in[0] && clr_v[DIC_T_ERR][0])
      |=> pend_v[DIC_T_ERR][0])
    else $error("set lost against clear");
  a_sum_read: assert property (s_sum_rd |=> hrdata_out == {27'h0, $past(summary)})
    else $error("summary read mismatch");
  a_irq_order: assert property (##1 error_irq_out == $past(|stat_v[4])
      && transfer_done_irq_out == $past(|stat_v[0]))
    else $error("summary bit order wrong");
  a_reserved_zero: assert property (hrdata_out[31:10] == 22'h0
      && hrdata_out[7:5] == 3'h0)
    else $error("reserved bits read nonzero");
  a_mask_strobe1: assert property (s_mask_wr |=> st.err_mask[1] ==
      ($past(hwdata_in[9]) ? $past(hwdata_in[1]) : $past(st.err_mask[1])))
    else $error("mask bit 1 strobe misbehaved");
  a_mask_read: assert property (s_mask_rd |=> hrdata_out == {30'h0, $past(st.err_mask)})
    else $error("mask read mismatch");
  a_wo_read: assert property (s_wo_rd |=> hrdata_out == 32'h0)
    else $error("write-only or unmapped read nonzero");
  a_rdata_idle: assert property (!(addr_valid && !hwrite_in) |=> hrdata_out == 32'h0)
    else $error("read data not zero outside a read");
  a_dst_or: assert property (summary[DIC_T_DST] ==
      |(pend_v[DIC_T_DST] & dest_txn_mask_in))
    else $error("destination summary bit not an or");

endmodule

/* File: rtl/dic_pend.sv */
// pending bits of one interrupt type, with mask gating
`timescale 1ns/1ps
module dic_pend
  import dic_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic [1:0] set_in,
  input wire logic [1:0] clr_in,
  input wire logic [1:0] mask_in,
  output logic [1:0] pend_out,
  output logic [1:0] status_out
);

  typedef struct packed {
    logic [1:0] pend;
  } dic_pend_state_t;

  dic_pend_state_t st;
  dic_pend_state_t next_st;

  always_comb begin
    next_st = st;
    // set beats clear in the same cycle
    next_st.pend = (st.pend & ~clr_in) | set_in;
  end

  always_ff @(posedge core_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st.pend <= DIC_PEND_RST;
    end else begin
      st <= next_st;
    end
  end

  assign pend_out = st.pend;
  assign status_out = st.pend & mask_in;

endmodule

/* File: rtl/dic_pkg.sv */
// constants and types for the dma interrupt mask, clear and summary slice
// Notes on behaviour
// - visible error status is raw gated by mask
// - error mask bits 1:0, reset zero, one unmasks
// - mask bit written only with its strobe
// - writing one to clear bit clears pending
// - summary bit is OR of type status
// - summary bits: 4 err,3 dst,2 src,1 blk,0 tfr
package dic_pkg;

  // ************************************************************
  // register byte addresses
  // ************************************************************
  localparam logic [31:0] DIC_ADDR_ERR_MASK = 32'hb0700330;
  localparam logic [31:0] DIC_ADDR_CLR_TFR = 32'hb0700338;
  localparam logic [31:0] DIC_ADDR_CLR_BLK = 32'hb0700340;
  localparam logic [31:0] DIC_ADDR_CLR_SRC = 32'hb0700348;
  localparam logic [31:0] DIC_ADDR_CLR_DST = 32'hb0700350;
  localparam logic [31:0] DIC_ADDR_CLR_ERR = 32'hb0700358;
  localparam logic [31:0] DIC_ADDR_SUMMARY = 32'hb0700360;

  // ************************************************************
  // fields and reset values
  // ************************************************************
  localparam int DIC_NCH = 2;
  localparam int DIC_NTYPE = 5;
  localparam int DIC_MASK_LSB = 0;
  localparam int DIC_STRB_LSB = 8;
  localparam int DIC_CLR_LSB = 0;
  localparam int DIC_T_TFR = 0;
  localparam int DIC_T_BLK = 1;
  localparam int DIC_T_SRC = 2;
  localparam int DIC_T_DST = 3;
  localparam int DIC_T_ERR = 4;
  localparam logic [1:0] DIC_MASK_RST = 2'h0;
  localparam logic [1:0] DIC_PEND_RST = 2'h0;
  localparam logic [31:0] DIC_RDATA_RST = 32'h00000000;
  localparam logic [4:0] DIC_IRQ_RST = 5'h00;
  localparam logic [1:0] DIC_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DIC_HTRANS_SEQ = 2'h3;

  typedef enum logic [2:0] {
    DIC_REG_NONE,
    DIC_REG_MASK,
    DIC_REG_CLR_TFR,
    DIC_REG_CLR_BLK,
    DIC_REG_CLR_SRC,
    DIC_REG_CLR_DST,
    DIC_REG_CLR_ERR,
    DIC_REG_SUMMARY
  } dic_reg_t;

endpackage

/* File: verif/tb_dic_irq_slice.sv */
// self-checking bench for the dma interrupt mask, clear and summary slice
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin n_errors++; \
  $display("FAIL t=%0t got %0h exp %0h", $time, got, exp); end end
module tb_dic_irq_slice;
  import dic_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [31:0] haddr = 32'h00000000;
  logic [31:0] hwdata = 32'h00000000;
  logic [4:0][1:0] setv = '0;
  logic [3:0][1:0] omask = '1;
  wire [31:0] hrdata;
  wire hreadyout;
  wire hresp;
  wire [1:0] emask;
  wire [4:0] irqv;
  int n_errors = 0;
  int n_checks = 0;

  always #4 core_clk = ~core_clk;

  dic_irq_slice uut (
    .core_clk_in(core_clk), .rstn_in(rstn), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hreadyout),
    .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .transfer_done_set_in(setv[0]), .block_done_set_in(setv[1]),
    .source_txn_set_in(setv[2]), .dest_txn_set_in(setv[3]), .error_set_in(setv[4]),
    .transfer_done_mask_in(omask[0]), .block_done_mask_in(omask[1]),
    .source_txn_mask_in(omask[2]), .dest_txn_mask_in(omask[3]),
    .error_irq_mask_out(emask), .transfer_done_irq_out(irqv[0]),
    .block_done_irq_out(irqv[1]), .source_txn_irq_out(irqv[2]),
    .dest_txn_irq_out(irqv[3]), .error_irq_out(irqv[4])
  );

  // ************************************************************
  // access tasks
  // ************************************************************
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_rdy;
    int k;
    for (k = 0; k < 16 && hreadyout !== 1'b1; k++) begin
      @(negedge core_clk);
    end
    if (k == 16) begin
      n_errors++;
      $display("FAIL t=%0t ready never seen", $time);
      wrap_up;
    end
  endtask

  task automatic ahb_wr(input logic [31:0] a, input logic [31:0] d);
    @(negedge core_clk);
    wait_rdy;
    hsel = 1'b1;
    haddr = a;
    htrans = DIC_HTRANS_NONSEQ;
    hwrite = 1'b1;
    @(negedge core_clk);
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = d;
    wait_rdy;
    @(negedge core_clk);
  endtask

  task automatic ahb_rd(input logic [31:0] a, input logic [31:0] exp);
    @(negedge core_clk);
    wait_rdy;
    hsel = 1'b1;
    haddr = a;
    htrans = DIC_HTRANS_NONSEQ;
    hwrite = 1'b0;
    @(negedge core_clk);
    hsel = 1'b0;
    htrans = 2'h0;
    wait_rdy;
    `CHK(hrdata, exp)
    `CHK(hresp, 1'b0)
    `CHK(hreadyout, 1'b1)
  endtask

  // one-cycle event; irq visible at return
  task automatic pulse(input int t, input logic [1:0] v);
    @(negedge core_clk);
    setv[t] = v;
    @(negedge core_clk);
    setv[t] = 2'h0;
    @(negedge core_clk);
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    logic [31:0] clr_addr;
    repeat (8) @(negedge core_clk);
    rstn = 1'b1;
    `CHK(emask, 2'h0)
    `CHK(irqv, 5'h00)
    ahb_rd(DIC_ADDR_ERR_MASK, 32'h0);
    ahb_wr(DIC_ADDR_ERR_MASK, 32'hfffffcff);
    `CHK(emask, 2'h0)
    ahb_wr(DIC_ADDR_ERR_MASK, 32'h000001ff);
    `CHK(emask, 2'h1)
    ahb_rd(DIC_ADDR_ERR_MASK, 32'h1);
    pulse(4, 2'h2);
    `CHK(irqv[4], 1'b0)
    ahb_rd(DIC_ADDR_SUMMARY, 32'h0);
    ahb_wr(DIC_ADDR_ERR_MASK, 32'h00000202);
    @(negedge core_clk);
    `CHK(irqv[4], 1'b1)
    `CHK(emask, 2'h3)
    ahb_rd(DIC_ADDR_SUMMARY, 32'h10);
    ahb_wr(DIC_ADDR_ERR_MASK, 32'h00000100);
    `CHK(emask, 2'h2)
    ahb_wr(DIC_ADDR_ERR_MASK, 32'h00000101);
    `CHK(emask, 2'h3)
    // drop the error left pending above before the per-type loop
    ahb_wr(DIC_ADDR_CLR_ERR, 32'h00000002);
    @(negedge core_clk);
    `CHK(irqv, 5'h00)
    // every type: set, partial clear, full clear
    for (int t = 0; t < DIC_NTYPE; t++) begin
      clr_addr = DIC_ADDR_CLR_TFR + 32'(8 * t);
      pulse(t, 2'h2);
      `CHK(irqv, 5'(1 << t))
      ahb_rd(DIC_ADDR_SUMMARY, 32'(1 << t));
      ahb_wr(clr_addr, 32'hfffffffd);
      @(negedge core_clk);
      `CHK(irqv, 5'(1 << t))
      ahb_wr(clr_addr, 32'h00000002);
      @(negedge core_clk);
      `CHK(irqv, 5'h00)
      ahb_rd(DIC_ADDR_SUMMARY, 32'h0);
    end
    // set and clear in one cycle: set wins
    fork
      ahb_wr(DIC_ADDR_CLR_ERR, 32'h00000001);
      begin
        repeat (2) @(negedge core_clk);
        setv[4] = 2'h1;
        @(negedge core_clk);
        setv[4] = 2'h0;
      end
    join
    @(negedge core_clk);
    `CHK(irqv, 5'h10)
    ahb_wr(DIC_ADDR_CLR_ERR, 32'h00000001);
    @(negedge core_clk);
    `CHK(irqv, 5'h00)
    // read-only, write-only and unmapped places
    pulse(0, 2'h1);
    ahb_wr(DIC_ADDR_CLR_TFR, 32'h00000002);
    ahb_wr(DIC_ADDR_SUMMARY, 32'h00000000);
    ahb_wr(32'hb0700364, 32'hffffffff);
    ahb_rd(DIC_ADDR_SUMMARY, 32'h1);
    ahb_rd(DIC_ADDR_CLR_TFR, 32'h0);
    ahb_rd(32'hb0700364, 32'h0);
    `CHK(emask, 2'h3)
    // second reset in mid-run
    @(negedge core_clk);
    rstn = 1'b0;
    @(negedge core_clk);
    rstn = 1'b1;
    `CHK(emask, 2'h0)
    `CHK(irqv, 5'h00)
    ahb_rd(DIC_ADDR_SUMMARY, 32'h0);
    wrap_up;
  end
endmodule
